// ==== verilog/cma_core.sv ====
// Memory addressing unit of the 8-bit core: stack, program counter, core
// registers, bank and pointer decode. Assumes data and program memories
// answer reads combinationally in the cycle the address is presented.
`timescale 1ns/1ps

module cma_core
  import cma_pkg::*;
#(
  parameter int STACK_ENTRIES = cma_pkg::STACK_DEPTH
)
(
  // Clock and reset
  input  wire logic                CLK,
  input  wire logic                RST_B,
  // File register request from the execution logic
  input  cma_pkg::cma_file_req_t   FILE_REQ,
  output logic [7:0]               FILE_RDATA,
  output logic                     FILE_RVALID,
  output logic                     BUSY,
  output logic                     HEF_HIT,
  // Program counter control
  input  cma_pkg::cma_pc_op_t      PC_OP,
  input  wire logic [10:0]         PC_TARGET,
  output logic [14:0]              PC,
  // Working register and flags from the ALU
  input  wire logic                W_WR,
  input  wire logic [7:0]          W_WDATA,
  input  wire logic [2:0]          ALU_FLAG_WE,
  input  wire logic [2:0]          ALU_FLAGS,
  input  wire logic [1:0]          PWR_TO_PD,
  output logic [7:0]               W_OUT,
  output logic [7:0]               STATUS_OUT,
  output logic [7:0]               INTERRUPT_CONTROL_OUT,
  // Stack fault flags, held in the power control register
  input  wire logic                STACK_RESET_EN,
  input  wire logic                STACK_FLAG_CLR,
  output logic                     STACK_OVF_FLAG,
  output logic                     STACK_UNF_FLAG,
  output logic                     SOFT_RESET,
  // Data memory port
  output logic [11:0]              DM_ADDR,
  output logic                     DM_RD,
  output logic                     DM_WR,
  output logic [7:0]               DM_WDATA,
  input  wire logic [7:0]          DM_RDATA,
  input  wire logic                DM_HIT,
  // Program memory read port
  output logic [14:0]              PM_ADDR,
  output logic                     PM_RD,
  input  wire logic [13:0]         PM_RDATA
);
  import cma_pkg::*;

  typedef enum logic [0:0] {
    CMA_ST_IDLE = 1'b0,
    CMA_ST_PROG = 1'b1
  } cma_state_t;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  cma_state_t     state_q;
  logic [14:0]    pc_q;
  logic [14:0]    pm_addr_q;
  logic [7:0]     working_register_q;
  logic [7:0]     bank_q;
  logic [7:0]     program_counter_high_latch_q;
  logic [7:0]     interrupt_control_q;
  logic [15:0]    ptr0_q;
  logic [15:0]    ptr1_q;
  logic [2:0]     flags_q;
  logic [7:0]     rdata_q;
  logic           rvalid_q;
  logic           to_w_q;
  logic           hef_q;
  logic [14:0]    stack_q [STACK_ENTRIES];
  logic [4:0]     depth_q;
  logic           ovf_q;
  logic           unf_q;
  logic           soft_rst_q;
  cma_shadow_t    shadow_q;

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------
  function automatic logic [14:0] wrap(input logic [14:0] a);
    wrap = a & PROG_MASK;
  endfunction

  function automatic cma_target_t map_bank(input logic [4:0] bank, input logic [6:0] ofs);
    cma_target_t t;
    t.paddr = 15'h0000;
    if (ofs <= OFS_CORE_LAST)
    begin
      t.kind  = CMA_TGT_CORE;
      t.daddr = {5'h00, ofs};
    end
    else if (ofs >= OFS_COMMON)
    begin
      // Common RAM is one physical block, so every bank lands on bank zero.
      t.kind  = CMA_TGT_DATA;
      t.daddr = {5'h00, ofs};
    end
    else
    begin
      t.kind  = CMA_TGT_DATA;
      t.daddr = {bank, ofs};
    end
    return t;
  endfunction

  function automatic cma_target_t map_ptr(input logic [15:0] p);
    cma_target_t t;
    logic [12:0] lin;
    logic [12:0] lbank;
    logic [12:0] lofs;
    lin   = 13'(p - LIN_BASE);
    lbank = lin / LIN_PER_BANK;
    lofs  = lin % LIN_PER_BANK;
    t.kind  = CMA_TGT_NONE;
    t.daddr = 12'h000;
    t.paddr = 15'h0000;
    if (p[PTR_PROG_BIT])
    begin
      t.kind  = CMA_TGT_PROG;
      t.paddr = wrap(p[14:0]);
    end
    else if (p[15:12] == 4'h0)
    begin
      t = map_bank(p[11:7], p[6:0]);
    end
    else if (p >= LIN_BASE && lin < LIN_SPAN)
    begin
      t.kind  = CMA_TGT_DATA;
      t.daddr = {lbank[4:0], 7'(OFS_GPR_FIRST + lofs[6:0])};
    end
    return t;
  endfunction

  // ----------------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------------
  cma_target_t tgt;
  logic        take;
  logic        indirect;
  logic        core_wr;
  logic        pm_rd_take;
  logic [6:0]  core_ofs;
  logic [7:0]  core_rd;

  assign take     = (FILE_REQ.rd || FILE_REQ.wr) && state_q == CMA_ST_IDLE;
  assign indirect = FILE_REQ.addr == OFS_INDIRECT_DATA_PORT_0 || FILE_REQ.addr == OFS_INDIRECT_DATA_PORT_1;

  always_comb
  begin
    if (FILE_REQ.addr == OFS_INDIRECT_DATA_PORT_1)
    begin
      tgt = map_ptr(ptr1_q);
    end
    else if (FILE_REQ.addr == OFS_INDIRECT_DATA_PORT_0)
    begin
      tgt = map_ptr(ptr0_q);
    end
    else
    begin
      tgt = map_bank(bank_q[4:0], FILE_REQ.addr);
    end
  end

  // A pointer aimed at a data port itself reaches nothing, avoiding a loop.
  assign core_ofs = tgt.daddr[6:0];
  assign core_wr  = take && FILE_REQ.wr && tgt.kind == CMA_TGT_CORE
                    && core_ofs != OFS_INDIRECT_DATA_PORT_0 && core_ofs != OFS_INDIRECT_DATA_PORT_1;
  assign pm_rd_take = take && FILE_REQ.rd && tgt.kind == CMA_TGT_PROG;

  always_comb
  begin
    case (core_ofs)
      OFS_PCL:     core_rd = pc_q[7:0];
      OFS_STATUS:  core_rd = STATUS_OUT;
      OFS_PTR0_LO: core_rd = ptr0_q[7:0];
      OFS_PTR0_HI: core_rd = ptr0_q[15:8];
      OFS_PTR1_LO: core_rd = ptr1_q[7:0];
      OFS_PTR1_HI: core_rd = ptr1_q[15:8];
      OFS_BANK:    core_rd = bank_q;
      OFS_WORKING_REGISTER:    core_rd = working_register_q;
      OFS_PROGRAM_COUNTER_HIGH_LATCH:  core_rd = program_counter_high_latch_q;
      OFS_INTERRUPT_CONTROL:  core_rd = interrupt_control_q;
      default:     core_rd = RST_BYTE;
    endcase
  end

  assign DM_ADDR  = tgt.daddr;
  assign DM_RD    = take && FILE_REQ.rd && tgt.kind == CMA_TGT_DATA;
  // Program-memory targets have no write path at all, so such writes vanish.
  assign DM_WR    = take && FILE_REQ.wr && tgt.kind == CMA_TGT_DATA;
  assign DM_WDATA = FILE_REQ.wdata;
  assign PM_ADDR  = pm_addr_q;
  assign PM_RD    = state_q == CMA_ST_PROG;
  assign BUSY     = state_q == CMA_ST_PROG;

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      state_q   <= CMA_ST_IDLE;
      pm_addr_q <= VEC_RESET;
      rdata_q   <= RST_BYTE;
      rvalid_q  <= 1'b0;
      to_w_q    <= 1'b0;
      hef_q     <= 1'b0;
    end
    else
    begin
      rvalid_q <= 1'b0;
      case (state_q)
        CMA_ST_IDLE:
        begin
          if (pm_rd_take)
          begin
            // The program word needs its own cycle on the program port.
            state_q   <= CMA_ST_PROG;
            pm_addr_q <= tgt.paddr;
            to_w_q    <= FILE_REQ.to_w;
          end
          else if (take && FILE_REQ.rd)
          begin
            rvalid_q <= 1'b1;
            to_w_q   <= FILE_REQ.to_w;
            hef_q    <= 1'b0;
            if (tgt.kind == CMA_TGT_CORE)
            begin
              rdata_q <= core_rd;
            end
            else if (tgt.kind == CMA_TGT_DATA && DM_HIT)
            begin
              rdata_q <= DM_RDATA;
            end
            else
            begin
              rdata_q <= RST_BYTE;
            end
          end
        end
        CMA_ST_PROG:
        begin
          state_q  <= CMA_ST_IDLE;
          rvalid_q <= 1'b1;
          rdata_q  <= PM_RDATA[7:0];
          hef_q    <= pm_addr_q >= HEF_FIRST && pm_addr_q <= HEF_LAST;
        end
        default: state_q <= CMA_ST_IDLE;
      endcase
    end
  end

  assign FILE_RDATA  = rdata_q;
  assign FILE_RVALID = rvalid_q;
  assign HEF_HIT     = hef_q;

  // ----------------------------------------------------------------------
  // Working, bank, latch and interrupt control registers
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      working_register_q   <= RST_BYTE;
      bank_q   <= RST_BYTE;
      program_counter_high_latch_q <= RST_BYTE;
      interrupt_control_q <= RST_BYTE;
    end
    else if (PC_OP == CMA_PC_RETI)
    begin
      working_register_q   <= shadow_q.working_register;
      bank_q   <= shadow_q.bank;
      program_counter_high_latch_q <= shadow_q.program_counter_high_latch;
      interrupt_control_q[INTERRUPT_CONTROL_GIE_BIT] <= 1'b1;
    end
    else
    begin
      if (rvalid_q && to_w_q)
      begin
        working_register_q <= rdata_q;
      end
      else if (core_wr && core_ofs == OFS_WORKING_REGISTER)
      begin
        working_register_q <= FILE_REQ.wdata;
      end
      else if (W_WR)
      begin
        working_register_q <= W_WDATA;
      end
      if (core_wr && core_ofs == OFS_BANK)
      begin
        bank_q <= {3'h0, FILE_REQ.wdata[4:0]};
      end
      if (core_wr && core_ofs == OFS_PROGRAM_COUNTER_HIGH_LATCH)
      begin
        program_counter_high_latch_q <= {1'b0, FILE_REQ.wdata[6:0]};
      end
      if (PC_OP == CMA_PC_IRQ)
      begin
        interrupt_control_q[INTERRUPT_CONTROL_GIE_BIT] <= 1'b0;
      end
      else if (core_wr && core_ofs == OFS_INTERRUPT_CONTROL)
      begin
        interrupt_control_q <= FILE_REQ.wdata;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Pointers
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      ptr0_q <= {RST_BYTE, RST_BYTE};
      ptr1_q <= {RST_BYTE, RST_BYTE};
    end
    else if (PC_OP == CMA_PC_RETI)
    begin
      ptr0_q <= shadow_q.ptr0;
      ptr1_q <= shadow_q.ptr1;
    end
    else if (core_wr)
    begin
      case (core_ofs)
        OFS_PTR0_LO: ptr0_q[7:0]  <= FILE_REQ.wdata;
        OFS_PTR0_HI: ptr0_q[15:8] <= FILE_REQ.wdata;
        OFS_PTR1_LO: ptr1_q[7:0]  <= FILE_REQ.wdata;
        OFS_PTR1_HI: ptr1_q[15:8] <= FILE_REQ.wdata;
        default:     ptr0_q       <= ptr0_q;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      flags_q <= RST_FLAGS;
    end
    else if (PC_OP == CMA_PC_RETI)
    begin
      flags_q <= shadow_q.flags;
    end
    else
    begin
      for (int i = 0; i < 3; i++)
      begin
        if (ALU_FLAG_WE[i])
        begin
          flags_q[i] <= ALU_FLAGS[i];
        end
        else if (core_wr && core_ofs == OFS_STATUS && !FILE_REQ.flag_protect)
        begin
          flags_q[i] <= FILE_REQ.wdata[i];
        end
      end
    end
  end

  // Time-out and power-down are owned by the power logic and read only here.
  assign STATUS_OUT = {3'h0, PWR_TO_PD, flags_q};
  assign INTERRUPT_CONTROL_OUT = interrupt_control_q;
  assign W_OUT      = working_register_q;

  // ----------------------------------------------------------------------
  // Shadow registers
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      shadow_q <= '0;
    end
    else if (PC_OP == CMA_PC_IRQ)
    begin
      shadow_q <= '{working_register: working_register_q, bank: bank_q, program_counter_high_latch: program_counter_high_latch_q,
                    ptr0: ptr0_q, ptr1: ptr1_q, flags: flags_q};
    end
  end

  // ----------------------------------------------------------------------
  // Return stack and program counter
  // ----------------------------------------------------------------------
  logic        push;
  logic        pop;
  logic        push_ovf;
  logic        pop_unf;
  logic [14:0] push_addr;
  logic [14:0] pop_addr;

  assign push      = PC_OP == CMA_PC_CALL || PC_OP == CMA_PC_IRQ;
  assign pop       = PC_OP == CMA_PC_RET || PC_OP == CMA_PC_RETI;
  assign push_ovf  = push && depth_q == 5'(STACK_ENTRIES);
  assign pop_unf   = pop && depth_q == 5'h00;
  assign push_addr = PC_OP == CMA_PC_IRQ ? pc_q : wrap(15'(pc_q + 15'h0001));
  assign pop_addr  = pop_unf ? VEC_RESET : stack_q[4'(depth_q - 5'h01)];

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      depth_q <= 5'h00;
      for (int i = 0; i < STACK_ENTRIES; i++)
      begin
        stack_q[i] <= VEC_RESET;
      end
    end
    else if (push && !push_ovf)
    begin
      stack_q[4'(depth_q)] <= push_addr;
      depth_q <= 5'(depth_q + 5'h01);
    end
    else if (pop && !pop_unf)
    begin
      depth_q <= 5'(depth_q - 5'h01);
    end
  end

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      ovf_q      <= 1'b0;
      unf_q      <= 1'b0;
      soft_rst_q <= 1'b0;
    end
    else
    begin
      // A fault in the cycle of a clear still lands.
      ovf_q      <= push_ovf || (ovf_q && !STACK_FLAG_CLR);
      unf_q      <= pop_unf || (unf_q && !STACK_FLAG_CLR);
      soft_rst_q <= (push_ovf || pop_unf) && STACK_RESET_EN;
    end
  end

  assign STACK_OVF_FLAG = ovf_q;
  assign STACK_UNF_FLAG = unf_q;
  assign SOFT_RESET     = soft_rst_q;

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      pc_q <= VEC_RESET;
    end
    else if (core_wr && core_ofs == OFS_PCL)
    begin
      pc_q <= wrap({program_counter_high_latch_q[6:0], FILE_REQ.wdata});
    end
    else
    begin
      case (PC_OP)
        CMA_PC_STEP: pc_q <= wrap(15'(pc_q + 15'h0001));
        CMA_PC_GOTO: pc_q <= wrap({program_counter_high_latch_q[6:3], PC_TARGET});
        CMA_PC_CALL: pc_q <= wrap({program_counter_high_latch_q[6:3], PC_TARGET});
        CMA_PC_RET:  pc_q <= pop_addr;
        CMA_PC_RETI: pc_q <= pop_addr;
        CMA_PC_IRQ:  pc_q <= VEC_IRQ;
        CMA_PC_BRW:  pc_q <= wrap(15'(pc_q + 15'h0001 + {7'h00, working_register_q}));
        default:     pc_q <= pc_q;
      endcase
    end
  end

  assign PC = pc_q;

endmodule

// ==== verilog/cma_pkg.sv ====
// Constants, types and carriers for the core memory addressing block.
// Assumes a single instruction clock and an external data and program memory.
package cma_pkg;

  // ----------------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------------
  localparam int STACK_DEPTH   = 16;
  localparam int PC_W          = 15;
  localparam int PROG_WORDS    = 2048;
  localparam int DADDR_W       = 12;
  localparam int BANK_COUNT    = 32;
  localparam int GPR_PER_BANK  = 80;

  // ----------------------------------------------------------------------
  // Core register offsets within every bank
  // ----------------------------------------------------------------------
  localparam logic [6:0] OFS_INDIRECT_DATA_PORT_0   = 7'h00;
  localparam logic [6:0] OFS_INDIRECT_DATA_PORT_1   = 7'h01;
  localparam logic [6:0] OFS_PCL     = 7'h02;
  localparam logic [6:0] OFS_STATUS  = 7'h03;
  localparam logic [6:0] OFS_PTR0_LO = 7'h04;
  localparam logic [6:0] OFS_PTR0_HI = 7'h05;
  localparam logic [6:0] OFS_PTR1_LO = 7'h06;
  localparam logic [6:0] OFS_PTR1_HI = 7'h07;
  localparam logic [6:0] OFS_BANK    = 7'h08;
  localparam logic [6:0] OFS_WORKING_REGISTER    = 7'h09;
  localparam logic [6:0] OFS_PROGRAM_COUNTER_HIGH_LATCH  = 7'h0a;
  localparam logic [6:0] OFS_INTERRUPT_CONTROL  = 7'h0b;
  localparam logic [6:0] OFS_CORE_LAST = 7'h0b;
  localparam logic [6:0] OFS_GPR_FIRST = 7'h20;
  localparam logic [6:0] OFS_COMMON    = 7'h70;

  // ----------------------------------------------------------------------
  // Program space
  // ----------------------------------------------------------------------
  localparam logic [14:0] PROG_MASK  = 15'h07ff;
  localparam logic [14:0] VEC_RESET  = 15'h0000;
  localparam logic [14:0] VEC_IRQ    = 15'h0004;
  localparam logic [14:0] HEF_FIRST  = 15'h0780;
  localparam logic [14:0] HEF_LAST   = 15'h07ff;

  // ----------------------------------------------------------------------
  // Pointer map
  // ----------------------------------------------------------------------
  localparam int          PTR_PROG_BIT = 15;
  localparam logic [15:0] LIN_BASE     = 16'h2000;
  localparam logic [12:0] LIN_SPAN     = 13'h0a00;
  localparam logic [12:0] LIN_PER_BANK = 13'h0050;

  // ----------------------------------------------------------------------
  // Reset values and bit positions
  // ----------------------------------------------------------------------
  localparam logic [7:0] RST_BYTE  = 8'h00;
  localparam logic [2:0] RST_FLAGS = 3'h0;
  localparam int         INTERRUPT_CONTROL_GIE_BIT = 7;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    CMA_PC_HOLD = 3'b000,
    CMA_PC_STEP = 3'b001,
    CMA_PC_GOTO = 3'b010,
    CMA_PC_CALL = 3'b011,
    CMA_PC_RET  = 3'b100,
    CMA_PC_RETI = 3'b101,
    CMA_PC_IRQ  = 3'b110,
    CMA_PC_BRW  = 3'b111
  } cma_pc_op_t;

  typedef enum logic [1:0] {
    CMA_TGT_NONE = 2'b00,
    CMA_TGT_CORE = 2'b01,
    CMA_TGT_DATA = 2'b10,
    CMA_TGT_PROG = 2'b11
  } cma_tgt_t;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic       to_w;
    logic       flag_protect;
    logic [6:0] addr;
    logic [7:0] wdata;
  } cma_file_req_t;

  typedef struct packed {
    cma_tgt_t    kind;
    logic [11:0] daddr;
    logic [14:0] paddr;
  } cma_target_t;

  typedef struct packed {
    logic [7:0]  working_register;
    logic [7:0]  bank;
    logic [7:0]  program_counter_high_latch;
    logic [15:0] ptr0;
    logic [15:0] ptr1;
    logic [2:0]  flags;
  } cma_shadow_t;

endpackage

// ==== test/cma_mem_model.sv ====
// Behavioural data and program memory on the far side of the addressing unit.
// Assumes the unit reads data memory in the request cycle and program memory in the cycle after it.
`timescale 1ns/1ps
module cma_mem_model (
  // Data memory
  input  wire logic [11:0] DM_ADDR,
  output logic [7:0]       DM_RDATA,
  output logic             DM_HIT,
  // Program memory
  input  wire logic [14:0] PM_ADDR,
  input  wire logic        PM_RD,
  output logic [13:0]      PM_RDATA
);
  // Bank 31 is left empty so that reads of missing locations can be seen.
  assign DM_HIT   = DM_ADDR[11:7] != 5'h1f;
  assign DM_RDATA = DM_HIT ? DM_ADDR[7:0] ^ 8'h5a : ~DM_ADDR[7:0];
  // Outside a fetch the bus shows a different word, never the one fetched.
  assign PM_RDATA = PM_RD ? {3'h5, PM_ADDR[10:0]} ^ 14'h00c3 : ~{3'h0, PM_ADDR[10:0]};
endmodule

// ==== test/cma_core_checker.sv ====
// Port checks for the memory addressing unit.
// Assumes it is bound into the unit and sees only its ports.
`timescale 1ns/1ps
module cma_core_checker
  import cma_pkg::*;
#(
  parameter int STACK_ENTRIES = cma_pkg::STACK_DEPTH
)
(
  input  wire logic           CLK,
  input  wire logic           RST_B,
  input  cma_pkg::cma_file_req_t FILE_REQ,
  input  wire logic [7:0]     FILE_RDATA,
  input  wire logic           FILE_RVALID,
  input  wire logic           BUSY,
  input  wire logic           HEF_HIT,
  input  cma_pkg::cma_pc_op_t PC_OP,
  input  wire logic [14:0]    PC,
  input  wire logic           STACK_RESET_EN,
  input  wire logic           STACK_OVF_FLAG,
  input  wire logic           STACK_UNF_FLAG,
  input  wire logic           SOFT_RESET,
  input  wire logic [11:0]    DM_ADDR,
  input  wire logic           DM_RD,
  input  wire logic           DM_WR,
  input  wire logic [7:0]     DM_RDATA,
  input  wire logic           DM_HIT,
  input  wire logic [14:0]    PM_ADDR,
  input  wire logic           PM_RD,
  input  wire logic [13:0]    PM_RDATA
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_B);
  wire       pcl_wr = FILE_REQ.wr && !BUSY && FILE_REQ.addr == OFS_PCL;
  wire       take   = (FILE_REQ.rd || FILE_REQ.wr) && !BUSY;
  wire [7:0] pm_lo  = PM_RDATA[7:0];
  pc_range_a: assert property (PC <= PROG_MASK)
    else $error("program counter outside implemented space");
  pc_step_a: assert property (PC_OP == CMA_PC_STEP && !pcl_wr
    |=> PC == (($past(PC) + 15'h0001) & PROG_MASK))
    else $error("step did not advance and wrap");
  irq_vec_a: assert property (PC_OP == CMA_PC_IRQ && !pcl_wr |=> PC == VEC_IRQ)
    else $error("interrupt did not vector");
  prog_extra_a: assert property (BUSY |-> PM_RD ##1 (FILE_RVALID && !BUSY))
    else $error("program read not one extra cycle");
  prog_byte_a: assert property (BUSY |=> FILE_RDATA == $past(pm_lo))
    else $error("program read byte wrong");
  hef_flag_a: assert property (BUSY |=> HEF_HIT == ($past(PM_ADDR) >= HEF_FIRST))
    else $error("endurance flag wrong");
  empty_zero_a: assert property (take && FILE_REQ.rd && DM_RD
    |=> FILE_RVALID && FILE_RDATA == ($past(DM_HIT) ? $past(DM_RDATA) : 8'h00))
    else $error("data read answer wrong");
  core_local_a: assert property (take && FILE_REQ.addr inside {[7'h02:OFS_CORE_LAST]}
    |-> !DM_RD && !DM_WR)
    else $error("core register went to data memory");
  bank_ofs_a: assert property (take && FILE_REQ.rd && FILE_REQ.addr > OFS_CORE_LAST
    |-> DM_RD && DM_ADDR[6:0] == FILE_REQ.addr
        && (FILE_REQ.addr < OFS_COMMON || DM_ADDR[11:7] == 5'h00))
    else $error("direct address mapped wrong");
  soft_rst_a: assert property (($rose(STACK_OVF_FLAG) || $rose(STACK_UNF_FLAG))
    && $past(STACK_RESET_EN) |-> SOFT_RESET ##1 !SOFT_RESET)
    else $error("soft reset pulse wrong");
endmodule

bind cma_core cma_core_checker #(.STACK_ENTRIES(STACK_ENTRIES)) i_cma_core_checker (
  .CLK(CLK), .RST_B(RST_B), .FILE_REQ(FILE_REQ), .FILE_RDATA(FILE_RDATA),
  .FILE_RVALID(FILE_RVALID), .BUSY(BUSY), .HEF_HIT(HEF_HIT), .PC_OP(PC_OP), .PC(PC),
  .STACK_RESET_EN(STACK_RESET_EN), .STACK_OVF_FLAG(STACK_OVF_FLAG),
  .STACK_UNF_FLAG(STACK_UNF_FLAG), .SOFT_RESET(SOFT_RESET), .DM_ADDR(DM_ADDR),
  .DM_RD(DM_RD), .DM_WR(DM_WR), .DM_RDATA(DM_RDATA), .DM_HIT(DM_HIT),
  .PM_ADDR(PM_ADDR), .PM_RD(PM_RD), .PM_RDATA(PM_RDATA));

// ==== test/cma_core_tb_top.sv ====
// Self-checking bench for the memory addressing unit.
// Assumes the behavioural memory model stands on its memory ports.
`timescale 1ns/1ps
module cma_core_tb_top;
  import cma_pkg::*;
  logic CLK = 0, RST_B = 0, FILE_RVALID, BUSY, HEF_HIT, FCLR = 0, REN = 1;
  logic OVF, UNF, SOFT_RESET, DM_RD, DM_WR, DM_HIT, PM_RD;
  logic [2:0] FWE = '0, FL = '0;
  logic [7:0] FILE_RDATA, W_OUT, ST, IC, DM_WDATA, DM_RDATA, got, dwd;
  logic [10:0] TGT = '0;
  logic [11:0] DM_ADDR, dad;
  logic [13:0] PM_RDATA;
  logic [14:0] PC, PM_ADDR;
  logic dwr;
  cma_file_req_t FR = '0;
  cma_pc_op_t OP = CMA_PC_HOLD;
  int error_cnt = 0, checked = 0, n;
  always #4 CLK = ~CLK;
  cma_core i_cma_core (.CLK(CLK), .RST_B(RST_B), .FILE_REQ(FR), .FILE_RDATA(FILE_RDATA),
    .FILE_RVALID(FILE_RVALID), .BUSY(BUSY), .HEF_HIT(HEF_HIT), .PC_OP(OP),
    .PC_TARGET(TGT), .PC(PC), .W_WR(1'b0), .W_WDATA(8'h00), .ALU_FLAG_WE(FWE),
    .ALU_FLAGS(FL), .PWR_TO_PD(2'b11), .W_OUT(W_OUT), .STATUS_OUT(ST), .INTERRUPT_CONTROL_OUT(IC),
    .STACK_RESET_EN(REN), .STACK_FLAG_CLR(FCLR), .STACK_OVF_FLAG(OVF),
    .STACK_UNF_FLAG(UNF), .SOFT_RESET(SOFT_RESET), .DM_ADDR(DM_ADDR), .DM_RD(DM_RD),
    .DM_WR(DM_WR), .DM_WDATA(DM_WDATA), .DM_RDATA(DM_RDATA), .DM_HIT(DM_HIT),
    .PM_ADDR(PM_ADDR), .PM_RD(PM_RD), .PM_RDATA(PM_RDATA));
  cma_mem_model i_cma_mem_model (.DM_ADDR(DM_ADDR), .DM_RDATA(DM_RDATA), .DM_HIT(DM_HIT),
    .PM_ADDR(PM_ADDR), .PM_RD(PM_RD), .PM_RDATA(PM_RDATA));
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // A request is held from one rising edge to the next, where it is taken.
  task automatic req(input logic r, w, tw, fp, input logic [6:0] a, input logic [7:0] d);
    @(posedge CLK);
    FR <= {r, w, tw, fp, a, d};
    @(negedge CLK);
    dad = DM_ADDR;
    dwr = DM_WR;
    dwd = DM_WDATA;
    @(posedge CLK);
    FR <= '0;
    n = 0;
    while (r && n < 4)
    begin
      @(negedge CLK);
      n++;
      if (FILE_RVALID === 1'b1)
        break;
    end
    // A read that never completes yields unknown data, so stale data cannot pass.
    got = (FILE_RVALID === 1'b1) ? FILE_RDATA : 8'hxx;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    req(0, 1, 0, 0, a, d);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    req(1, 0, 0, 0, a, 8'h00);
    chk(got, e);
  endtask
  task automatic pcop(input cma_pc_op_t o, input logic [10:0] t, input logic [14:0] e);
    @(posedge CLK);
    OP <= o;
    TGT <= t;
    @(posedge CLK);
    OP <= CMA_PC_HOLD;
    @(negedge CLK);
    chk(PC, e);
  endtask
  initial
  begin
    #(8 * 3000);
    error_cnt++;
    close_out();
  end
  initial
  begin
    repeat (2) @(posedge CLK);
    RST_B <= 1'b1;
    @(negedge CLK);
    chk(PC, 15'h0000);
    pcop(CMA_PC_STEP, 11'h000, 15'h0001);
    wr(7'h0a, 8'h7f);
    pcop(CMA_PC_GOTO, 11'h7ff, 15'h07ff);
    pcop(CMA_PC_STEP, 11'h000, 15'h0000);
    pcop(CMA_PC_CALL, 11'h010, 15'h0010);
    pcop(CMA_PC_RET, 11'h000, 15'h0001);
    wr(7'h09, 8'h3c);
    pcop(CMA_PC_IRQ, 11'h000, 15'h0004);
    wr(7'h09, 8'h00);
    pcop(CMA_PC_RETI, 11'h000, 15'h0001);
    chk(W_OUT, 8'h3c);
    chk(IC[7], 1'b1);
    $display("program counter test done");
    wr(7'h08, 8'h03);
    rd(7'h25, 8'hff);
    chk(dad, 12'h1a5);
    rd(7'h75, 8'h2f);
    wr(7'h08, 8'h1f);
    rd(7'h30, 8'h00);
    rd(7'h09, 8'h3c);
    wr(7'h40, 8'h66);
    chk(dwr, 1'b1);
    chk(dad, 12'hfc0);
    chk(dwd, 8'h66);
    $display("bank test done");
    wr(7'h04, 8'h23);
    wr(7'h05, 8'h01);
    rd(7'h00, 8'h79);
    wr(7'h06, 8'h50);
    wr(7'h07, 8'h20);
    rd(7'h01, 8'hfa);
    chk(dad, 12'h0a0);
    wr(7'h04, 8'h90);
    wr(7'h05, 8'h87);
    req(1, 0, 1, 0, 7'h00, 8'h00);
    chk(got, 8'h53);
    chk(16'(n), 16'h0002);
    chk(HEF_HIT, 1'b1);
    rd(7'h09, 8'h53);
    wr(7'h00, 8'haa);
    chk(dwr, 1'b0);
    wr(7'h06, 8'h12);
    wr(7'h07, 8'hf9);
    rd(7'h01, 8'hd1);
    chk(HEF_HIT, 1'b0);
    $display("pointer test done");
    @(posedge CLK);
    FWE <= 3'b111;
    FL <= 3'b101;
    @(posedge CLK);
    FWE <= 3'b000;
    req(0, 1, 0, 1, 7'h03, 8'hff);
    @(negedge CLK);
    chk(ST, 8'h1d);
    wr(7'h03, 8'h02);
    @(negedge CLK);
    chk(ST, 8'h1a);
    $display("status test done");
    repeat (16) pcop(CMA_PC_CALL, 11'h010, 15'h0010);
    chk(OVF, 1'b0);
    pcop(CMA_PC_CALL, 11'h010, 15'h0010);
    chk(SOFT_RESET, 1'b1);
    @(negedge CLK);
    chk(OVF, 1'b1);
    chk(SOFT_RESET, 1'b0);
    @(posedge CLK);
    FCLR <= 1'b1;
    @(posedge CLK);
    FCLR <= 1'b0;
    @(negedge CLK);
    chk(OVF, 1'b0);
    repeat (15) pcop(CMA_PC_RET, 11'h000, 15'h0011);
    pcop(CMA_PC_RET, 11'h000, 15'h0002);
    chk(UNF, 1'b0);
    // With the soft reset disabled the fault must only raise its flag.
    @(posedge CLK);
    REN <= 1'b0;
    pcop(CMA_PC_RET, 11'h000, 15'h0000);
    chk(SOFT_RESET, 1'b0);
    @(negedge CLK);
    chk(UNF, 1'b1);
    $display("stack test done");
    pcop(CMA_PC_BRW, 11'h000, 15'h0054);
    wr(7'h02, 8'h34);
    @(negedge CLK);
    chk(PC, 15'h0734);
    $display("branch test done");
    close_out();
  end
endmodule
